// *** core/timer2_compare_reload.sv ***
// Functional notes
// - Wrap from all ones sets overflow flag
// - Timer counts at osc/6 or osc/12
// - Gated mode counts only while gate high
// - Gate sampled once per machine cycle
// - Event mode counts count-pin falling edges
// - Count pin sampled once per machine cycle
// - Reload mode 0 reloads on overflow
// - Reload mode 1 reloads on trigger fall
// - Trigger fall sets event flag if enabled
// - Compare registers checked against counter continuously
// - Match drives output pin, raises flag
// - Four compare channels, 16-bit resolution
// - Four capture inputs latch the counter
// - Mode 0: set on match, clear overflow
// - Mode 1: shadow latch copied on match
`timescale 1ns/1ps
`default_nettype none

module timer2_compare_reload #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [timer2_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer2_pkg::DATA_W-1:0] pwdata,
  output logic [timer2_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_count_pin,
  input wire logic reload_trigger_pin,
  input wire logic [NCH-1:0] capture_pin,
  output logic [NCH-1:0] compare_out,
  output logic irq
);
  import timer2_pkg::*;

  // ***********************************************
  // Address decode helpers
  // ***********************************************
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'b00) begin
      if (a < OFS_CMP_BASE) begin
        ok = 1'b1;
      end else if ((a[7:4] == OFS_CMP_BASE[7:4]) || (a[7:4] == OFS_CAP_BASE[7:4])) begin
        ok = (32'(a[3:2]) < NCH);
      end
    end
    return ok;
  endfunction : addr_ok

  function automatic logic [1:0] chan_of(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction : chan_of

  // ***********************************************
  // State
  // ***********************************************
  logic [2:0] mc_cnt_q, mc_cnt_d;
  logic half_q, half_d;
  logic evt_smp_q, evt_smp_d;
  logic rld_smp_q, rld_smp_d;
  logic [NCH-1:0] cap_prev_q, cap_prev_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [15:0] reload_q, reload_d;
  logic [ST_W-1:0] status_q, status_d;
  logic [ST_W-1:0] irq_en_q, irq_en_d;
  logic [CH_W-1:0] chan_q, chan_d;
  logic [NCH-1:0] port_q, port_d;
  logic [NCH-1:0] out_q, out_d;
  logic [NCH-1:0] eq_q, eq_d;
  logic [15:0] cmp_q [NCH];
  logic [15:0] cmp_d [NCH];
  logic [15:0] cap_q [NCH];
  logic [15:0] cap_d [NCH];
  logic [DATA_W-1:0] prdata_q, prdata_d;

  logic mc_tick, rate_tick, inc, ovf, evt_fall, rld_fall;
  logic wr, setup, wr_count, do_reload;
  logic [NCH-1:0] match, cap_ev;
  logic [DATA_W-1:0] rd_val;
  run_mode_t run_mode;

  assign run_mode = run_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign wr = psel && penable && pwrite && addr_ok(paddr);
  assign setup = psel && !penable;
  assign wr_count = wr && (paddr == OFS_COUNT);

  // ***********************************************
  // Machine cycle and count enable
  // ***********************************************
  assign mc_tick = (mc_cnt_q == MC_LAST);
  assign rate_tick = mc_tick && (!ctrl_q[CTRL_PRESC_BIT] || half_q);
  // Two samples one machine cycle apart make a falling edge
  assign evt_fall = mc_tick && evt_smp_q && !gate_count_pin;
  assign rld_fall = mc_tick && rld_smp_q && !reload_trigger_pin;

  always_comb begin
    unique case (run_mode)
      RUN_STOP: inc = 1'b0;
      RUN_TIMER: inc = rate_tick;
      RUN_GATED: inc = rate_tick && gate_count_pin;
      RUN_EVENT: inc = evt_fall;
    endcase
  end

  assign ovf = inc && (count_q == 16'hffff);
  assign do_reload = ctrl_q[CTRL_RLD_EN_BIT] &&
    (ctrl_q[CTRL_RLD_MODE_BIT] ? rld_fall : ovf);

  // ***********************************************
  // Compare and capture events
  // ***********************************************
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      eq_d[i] = chan_q[CH_CMP_EN_LSB + i] && (count_q == cmp_q[i]);
      // Only the first cycle of equality counts as a match
      match[i] = eq_d[i] && !eq_q[i];
      cap_ev[i] = chan_q[CH_CAP_EN_LSB + i] && (chan_q[CH_CAP_EDGE_LSB + i] ?
        (!cap_prev_q[i] && capture_pin[i]) : (cap_prev_q[i] && !capture_pin[i]));
    end
  end

  // ***********************************************
  // Next state
  // ***********************************************
  always_comb begin
    mc_cnt_d = mc_tick ? 3'h0 : mc_cnt_q + 3'h1;
    half_d = mc_tick ? !half_q : half_q;
    evt_smp_d = mc_tick ? gate_count_pin : evt_smp_q;
    rld_smp_d = mc_tick ? reload_trigger_pin : rld_smp_q;
    cap_prev_d = capture_pin;
    ctrl_d = ctrl_q;
    reload_d = reload_q;
    irq_en_d = irq_en_q;
    chan_d = chan_q;
    port_d = port_q;
    cmp_d = cmp_q;
    cap_d = cap_q;
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
        OFS_RELOAD: reload_d = pwdata[15:0];
        OFS_IRQ_EN: irq_en_d = pwdata[ST_W-1:0];
        OFS_CHAN: chan_d = pwdata[CH_W-1:0];
        OFS_PORT: port_d = pwdata[NCH-1:0];
        default: begin
          if (paddr[7:4] == OFS_CMP_BASE[7:4]) begin
            cmp_d[chan_of(paddr)] = pwdata[15:0];
          end
        end
      endcase
    end
    // Software write beats reload, reload beats increment
    if (wr_count) begin
      count_d = pwdata[15:0];
    end else if (do_reload) begin
      count_d = reload_q;
    end else if (inc) begin
      count_d = count_q + 16'h0001;
    end else begin
      count_d = count_q;
    end
    for (int i = 0; i < NCH; i++) begin
      if (!chan_q[CH_CMP_EN_LSB + i]) begin
        out_d[i] = port_q[i];
      end else if (!chan_q[CH_CMP_MODE_LSB + i]) begin
        // Port writes never reach the pin here
        out_d[i] = match[i] ? 1'b1 : (ovf ? 1'b0 : out_q[i]);
      end else begin
        out_d[i] = match[i] ? port_q[i] : out_q[i];
      end
      if (cap_ev[i]) begin
        cap_d[i] = count_q;
      end
    end
    status_d = status_q;
    if (wr && (paddr == OFS_CLEAR)) begin
      status_d = status_q & ~pwdata[ST_W-1:0];
    end
    // Hardware set wins over a clear in the same cycle
    status_d[ST_OVF_BIT] = status_d[ST_OVF_BIT] || ovf;
    status_d[ST_EXT_BIT] = status_d[ST_EXT_BIT] ||
      (rld_fall && ctrl_q[CTRL_EXT_EN_BIT]);
    status_d[ST_CMP_LSB +: NCH] = status_d[ST_CMP_LSB +: NCH] | match;
    status_d[ST_CAP_LSB +: NCH] = status_d[ST_CAP_LSB +: NCH] | cap_ev;
  end

  // ***********************************************
  // Register read
  // ***********************************************
  always_comb begin
    rd_val = '0;
    if (addr_ok(paddr)) begin
      unique case (paddr)
        OFS_CTRL: rd_val[CTRL_W-1:0] = ctrl_q;
        OFS_COUNT: rd_val[15:0] = count_q;
        OFS_RELOAD: rd_val[15:0] = reload_q;
        OFS_STATUS: rd_val[ST_W-1:0] = status_q;
        OFS_IRQ_EN: rd_val[ST_W-1:0] = irq_en_q;
        OFS_CHAN: rd_val[CH_W-1:0] = chan_q;
        OFS_PORT: rd_val[NCH-1:0] = out_q;
        default: begin
          if (paddr[7:4] == OFS_CMP_BASE[7:4]) begin
            rd_val[15:0] = cmp_q[chan_of(paddr)];
          end else if (paddr[7:4] == OFS_CAP_BASE[7:4]) begin
            rd_val[15:0] = cap_q[chan_of(paddr)];
          end
        end
      endcase
    end
    // Latched in setup so the access phase sees stable flop data
    prdata_d = setup ? rd_val : prdata_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mc_cnt_q <= 3'h0;
      half_q <= 1'b0;
      evt_smp_q <= 1'b0;
      rld_smp_q <= 1'b0;
      cap_prev_q <= '0;
      ctrl_q <= CTRL_RST;
      count_q <= COUNT_RST;
      reload_q <= RELOAD_RST;
      status_q <= '0;
      irq_en_q <= IRQ_EN_RST;
      chan_q <= CHAN_RST;
      port_q <= '0;
      out_q <= '0;
      eq_q <= '0;
      prdata_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        cmp_q[i] <= CMP_RST;
        cap_q[i] <= COUNT_RST;
      end
    end else begin
      mc_cnt_q <= mc_cnt_d;
      half_q <= half_d;
      evt_smp_q <= evt_smp_d;
      rld_smp_q <= rld_smp_d;
      cap_prev_q <= cap_prev_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      reload_q <= reload_d;
      status_q <= status_d;
      irq_en_q <= irq_en_d;
      chan_q <= chan_d;
      port_q <= port_d;
      out_q <= out_d;
      eq_q <= eq_d;
      prdata_q <= prdata_d;
      cmp_q <= cmp_d;
      cap_q <= cap_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign compare_out = out_q;
  assign irq = |(status_q & irq_en_q);

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_ovf_flag_set: assert property (ovf |=> status_q[ST_OVF_BIT])
    else $error("overflow did not set flag");
  chk_mc_period: assert property (mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle is not six clocks");
  // Eleven quiet clocks split in two runs; a mode change may end the train
  chk_slow_rate: assert property ((run_mode == RUN_TIMER) && ctrl_q[CTRL_PRESC_BIT] && inc
    |=> !inc [*8] ##1 !inc [*3] ##1
    (inc || (run_mode != RUN_TIMER) || !ctrl_q[CTRL_PRESC_BIT]))
    else $error("divide by twelve rate wrong");
  chk_gate_halt: assert property ((run_mode == RUN_GATED) && !wr_count && !do_reload
    && (!mc_tick || !gate_count_pin) |=> $stable(count_q))
    else $error("gated count moved while halted");
  chk_event_step: assert property ((run_mode == RUN_EVENT) && evt_fall && !wr_count
    && !do_reload |=> count_q == $past(count_q) + 16'h0001)
    else $error("event edge did not add one");
  chk_reload_ovf: assert property (ovf && ctrl_q[CTRL_RLD_EN_BIT] && !ctrl_q[CTRL_RLD_MODE_BIT]
    && !wr_count |=> count_q == $past(reload_q))
    else $error("overflow reload wrong");
  chk_reload_pin: assert property (rld_fall && ctrl_q[CTRL_RLD_EN_BIT]
    && ctrl_q[CTRL_RLD_MODE_BIT] && !wr_count |=> count_q == $past(reload_q))
    else $error("trigger reload wrong");
  chk_ext_flag: assert property (rld_fall && ctrl_q[CTRL_EXT_EN_BIT] |=> status_q[ST_EXT_BIT])
    else $error("event flag not set");
  chk_ext_masked: assert property (!status_q[ST_EXT_BIT] && !(rld_fall && ctrl_q[CTRL_EXT_EN_BIT])
    |=> !status_q[ST_EXT_BIT])
    else $error("event flag set while disabled");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    chk_mode0_match: assert property (match[g] && !chan_q[CH_CMP_MODE_LSB + g]
      |=> compare_out[g] && status_q[ST_CMP_LSB + g])
      else $error("mode 0 match did not raise pin");
    chk_mode0_ovf: assert property (ovf && !match[g] && chan_q[CH_CMP_EN_LSB + g]
      && !chan_q[CH_CMP_MODE_LSB + g] |=> !compare_out[g])
      else $error("mode 0 overflow did not clear pin");
    chk_mode1_shadow: assert property (chan_q[CH_CMP_EN_LSB + g] && chan_q[CH_CMP_MODE_LSB + g]
      |=> compare_out[g] == ($past(match[g]) ? $past(port_q[g]) : $past(out_q[g])))
      else $error("mode 1 shadow transfer wrong");
    chk_capture: assert property (cap_ev[g]
      |=> cap_q[g] == $past(count_q) && status_q[ST_CAP_LSB + g])
      else $error("capture did not latch count");
  end

  cov_overflow_reload: cover property (ovf && do_reload);
  cov_pin_reload: cover property (rld_fall && do_reload);
  cov_compare_match: cover property (|match);
  cov_capture: cover property (|cap_ev);

endmodule : timer2_compare_reload

`default_nettype wire

// *** include/timer2_pkg.sv ***
package timer2_pkg;

  // ***********************************************
  // Bus geometry and register offsets
  // ***********************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_CHAN = 8'h18;
  localparam logic [7:0] OFS_PORT = 8'h1c;
  localparam logic [7:0] OFS_CMP_BASE = 8'h20;
  localparam logic [7:0] OFS_CAP_BASE = 8'h30;

  // ***********************************************
  // Field positions
  // ***********************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PRESC_BIT = 2;
  localparam int CTRL_RLD_MODE_BIT = 3;
  localparam int CTRL_RLD_EN_BIT = 4;
  localparam int CTRL_EXT_EN_BIT = 5;
  localparam int CTRL_W = 6;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_EXT_BIT = 1;
  localparam int ST_CMP_LSB = 2;
  localparam int ST_CAP_LSB = 6;
  localparam int ST_W = 10;
  localparam int CH_CMP_EN_LSB = 0;
  localparam int CH_CMP_MODE_LSB = 4;
  localparam int CH_CAP_EN_LSB = 8;
  localparam int CH_CAP_EDGE_LSB = 12;
  localparam int CH_W = 16;

  // ***********************************************
  // Reset values and timing
  // ***********************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hffff;
  localparam logic [CH_W-1:0] CHAN_RST = 16'h0000;
  localparam logic [ST_W-1:0] IRQ_EN_RST = 10'h000;
  // One machine cycle is six oscillator periods; oscillator is clk
  localparam int MC_OSC_PERIODS = 6;
  localparam logic [2:0] MC_LAST = 3'(MC_OSC_PERIODS - 1);

  typedef enum logic [1:0] {RUN_STOP, RUN_TIMER, RUN_GATED, RUN_EVENT} run_mode_t;

endpackage : timer2_pkg

// *** bench/timer2_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****
// Far side: gate/count, reload trigger and capture pins
// ****
module timer2_pin_model
  import timer2_pkg::*;
(
  input wire logic clk,
  output logic gate_count_pin,
  output logic reload_trigger_pin,
  output logic [3:0] capture_pin
);
  initial begin
    gate_count_pin = 1'b0;
    reload_trigger_pin = 1'b1;
    capture_pin = 4'h0;
  end

  // Whole machine cycles only, so each level is sampled at least once
  task automatic hold(input int mc);
    repeat (mc * MC_OSC_PERIODS) @(posedge clk);
  endtask : hold

  task automatic count_pulses(input int n, input int mc);
    repeat (n) begin
      gate_count_pin <= 1'b1;
      hold(mc);
      gate_count_pin <= 1'b0;
      hold(mc);
    end
  endtask : count_pulses

  task automatic gate_level(input logic lvl, input int mc);
    gate_count_pin <= lvl;
    hold(mc);
  endtask : gate_level

  task automatic trigger_fall(input int mc);
    reload_trigger_pin <= 1'b0;
    hold(mc);
    reload_trigger_pin <= 1'b1;
    hold(mc);
  endtask : trigger_fall

  task automatic cap_drive(input logic [3:0] v, input int mc);
    capture_pin <= v;
    hold(mc);
  endtask : cap_drive
endmodule : timer2_pin_model

`default_nettype wire

// *** bench/timer2_compare_reload_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module timer2_compare_reload_tb;
  import timer2_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, gate, rld, err;
  logic [3:0] cap, cmp_o;
  int n_fail = 0;
  int n_compared = 0;

  always #4 clk = ~clk;

  timer2_compare_reload #(.NCH(4)) DUT (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_count_pin(gate), .reload_trigger_pin(rld), .capture_pin(cap),
    .compare_out(cmp_o), .irq(irq));

  timer2_pin_model pins (.clk(clk), .gate_count_pin(gate), .reload_trigger_pin(rld),
    .capture_pin(cap));

  // ****
  // Shared bus and compare tasks
  // ****
  task automatic results;
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] lo, hi);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, lo, got);
    end
  endtask : chk

  // No wait-state count assumed; bounded wait for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] lo, hi);
    apb(1'b0, a, 32'h0);
    chk(nm, q, lo, hi);
  endtask : rd

  task automatic run(input logic [31:0] ctrl, input int mc);
    wr(OFS_CTRL, ctrl);
    repeat (mc * MC_OSC_PERIODS) @(posedge clk);
    wr(OFS_CTRL, 32'h0);
  endtask : run

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd("ctrl", OFS_CTRL, 0, 0);
    rd("cmp0", OFS_CMP_BASE, 32'hffff, 32'hffff);
    rd("status", OFS_STATUS, 0, 0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, err}, 1, 1);
    chk("unmapped data", q, 0, 0);
  endtask : t_reset

  task automatic t_timer;
    wr(OFS_COUNT, 0);
    run(32'h1, 20);
    rd("count div6", OFS_COUNT, 19, 22);
    wr(OFS_COUNT, 0);
    run(32'h5, 20);
    rd("count div12", OFS_COUNT, 9, 11);
  endtask : t_timer

  task automatic t_overflow;
    wr(OFS_RELOAD, 32'h1234);
    wr(OFS_COUNT, 32'hfff0);
    run(32'h11, 20);
    rd("reloaded", OFS_COUNT, 32'h1234, 32'h1239);
    apb(1'b0, OFS_STATUS, 0);
    chk("ovf flag", q & 32'h3, 1, 1);
    chk("irq masked", {31'h0, irq}, 0, 0);
    wr(OFS_IRQ_EN, 1);
    chk("irq on", {31'h0, irq}, 1, 1);
    wr(OFS_CLEAR, 32'h3ff);
    chk("irq off", {31'h0, irq}, 0, 0);
    wr(OFS_IRQ_EN, 0);
  endtask : t_overflow

  task automatic t_gate_event;
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL, 32'h2);
    pins.gate_level(1'b0, 10);
    rd("gate low", OFS_COUNT, 0, 0);
    pins.gate_level(1'b1, 10);
    pins.gate_level(1'b0, 4);
    rd("gate high", OFS_COUNT, 9, 11);
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL, 32'h3);
    pins.count_pulses(5, 1);
    pins.count_pulses(3, 3);
    wr(OFS_CTRL, 0);
    rd("events", OFS_COUNT, 8, 8);
  endtask : t_gate_event

  task automatic t_reload_pin;
    wr(OFS_RELOAD, 32'habcd);
    wr(OFS_COUNT, 5);
    wr(OFS_CTRL, 32'h18);
    pins.trigger_fall(1);
    rd("pin reload", OFS_COUNT, 32'habcd, 32'habcd);
    apb(1'b0, OFS_STATUS, 0);
    chk("no ext flag", q & 32'h3, 0, 0);
    wr(OFS_CTRL, 32'h38);
    pins.trigger_fall(2);
    apb(1'b0, OFS_STATUS, 0);
    chk("ext flag", q & 32'h3, 2, 2);
    wr(OFS_CTRL, 0);
    wr(OFS_CLEAR, 32'h3ff);
  endtask : t_reload_pin

  task automatic t_compare;
    wr(OFS_CHAN, 32'h000f);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CMP_BASE + 8'(4 * i), 32'h10 + 32'(i));
    end
    wr(OFS_COUNT, 32'h8);
    wr(OFS_PORT, 0);
    run(32'h1, 20);
    chk("mode0 set", {28'h0, cmp_o}, 32'hf, 32'hf);
    apb(1'b0, OFS_STATUS, 0);
    chk("cmp flags", (q >> 2) & 32'hf, 32'hf, 32'hf);
    wr(OFS_PORT, 0);
    chk("port ignored", {28'h0, cmp_o}, 32'hf, 32'hf);
    wr(OFS_COUNT, 32'hfffe);
    run(32'h1, 5);
    chk("mode0 clear", {28'h0, cmp_o}, 0, 0);
    wr(OFS_CHAN, 32'h00ff);
    wr(OFS_PORT, 32'h5);
    chk("shadow held", {28'h0, cmp_o}, 0, 0);
    wr(OFS_COUNT, 32'h8);
    run(32'h1, 20);
    chk("shadow out", {28'h0, cmp_o}, 5, 5);
  endtask : t_compare

  task automatic t_capture;
    wr(OFS_COUNT, 32'h4321);
    wr(OFS_CLEAR, 32'h3ff);
    wr(OFS_CHAN, 32'h2300);
    pins.cap_drive(4'h1, 1);
    pins.cap_drive(4'h2, 1);
    rd("cap0", OFS_CAP_BASE, 32'h4321, 32'h4321);
    rd("cap1", OFS_CAP_BASE + 8'h4, 32'h4321, 32'h4321);
    apb(1'b0, OFS_STATUS, 0);
    chk("cap flags", (q >> 6) & 32'hf, 3, 3);
  endtask : t_capture

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_overflow();
    t_gate_event();
    t_reload_pin();
    t_compare();
    t_capture();
    results();
  end
endmodule : timer2_compare_reload_tb

`default_nettype wire
